// ===== rtl/alarm_pkg.sv
package alarm_pkg;

    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int NUM_SP      = 4;
    localparam int DLY_W       = 16;
    // delays are counted in tenths of a second, 0.0 .. 3275.0 s
    localparam logic [15:0] DLY_MAX_TENTHS = 16'h7fee;
    localparam int CLK_HZ      = 25000000;
    localparam int TENTH_NS    = 100000000;
    localparam int TENTH_CYCLES = (CLK_HZ / 10);
    localparam int FLASH_TENTHS = 5;

    // ****************************************************************
    // register map, byte addresses
    // ****************************************************************
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] STATUS_OFS  = 8'h04;
    localparam logic [7:0] CMD_OFS     = 8'h08;
    localparam logic [7:0] CFG_OFS     = 8'h10;
    localparam logic [7:0] ONDLY_OFS   = 8'h20;
    localparam logic [7:0] OFFDLY_OFS  = 8'h30;

    // ctrl fields
    localparam int CTRL_ALT_LIST_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // per-setpoint config fields
    localparam int CFG_REV_BIT     = 0;
    localparam int CFG_ACT_LSB     = 1;
    localparam int CFG_STBY_BIT    = 3;
    localparam int CFG_IND_LSB     = 4;
    localparam int CFG_BURN_ON_BIT = 6;
    localparam int CFG_ENA_BIT     = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // command fields: bits 3:0 serial reset per setpoint
    localparam int CMD_RST_LSB = 0;

    // ****************************************************************
    // modes
    // ****************************************************************
    typedef enum logic [1:0] {
        AUTO_ACTION            = 2'b00,
        IMMEDIATE_LATCH_ACTION = 2'b01,
        DELAYED_LATCH_ACTION   = 2'b10
    } reset_action_e;

    typedef enum logic [1:0] {
        IND_OFF                 = 2'b00,
        IND_NORMAL              = 2'b01,
        IND_REVERSED            = 2'b10,
        FLASHING_INDICATOR_MODE = 2'b11
    } indicator_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ON_DLY = 2'b01,
        ST_ACTIVE = 2'b10,
        ST_OFF_DLY = 2'b11
    } alarm_state_e;

endpackage

// ===== rtl/setpoint_channel.sv
`timescale 1ns/100ps
module setpoint_channel (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        update,
    input  wire logic        tick,
    input  wire logic        trig,
    input  wire logic        below_sp,
    input  wire logic        probe_fail,
    input  wire logic        man_reset,
    input  wire logic        list_change,
    input  wire logic [7:0]  cfg,
    input  wire logic [15:0] on_dly,
    input  wire logic [15:0] off_dly,
    output logic             alarm_out,
    output logic             active
);
    typedef struct packed {
        alarm_pkg::alarm_state_e st;
        logic [15:0]             cnt;
        logic                    pend;
        logic                    armed;
        logic                    hold_off;
        logic                    init;
        logic                    out;
    } chan_s;

    chan_s state_reg;
    chan_s state_next;

    alarm_pkg::reset_action_e act;
    logic                     rev;
    logic                     stby;
    logic [15:0]              lead_dly;
    logic [15:0]              trail_dly;

    assign act       = alarm_pkg::reset_action_e'(cfg[alarm_pkg::CFG_ACT_LSB +: 2]);
    assign rev       = cfg[alarm_pkg::CFG_REV_BIT];
    assign stby      = cfg[alarm_pkg::CFG_STBY_BIT];
    // reversed logic swaps which edge each delay guards
    assign lead_dly  = rev ? off_dly : on_dly;
    assign trail_dly = rev ? on_dly : off_dly;

    always_comb begin
        state_next = state_reg;
        if (state_reg.init && update) begin
            // power-up: latches off when below setpoint
            state_next.init = 1'b0;
            if (below_sp) begin
                state_next.st = alarm_pkg::ST_IDLE;
            end
            state_next.pend = man_reset;
        end
        if (tick && state_reg.cnt != 16'h0000) begin
            state_next.cnt = state_reg.cnt - 16'h0001;
        end
        if (update && !state_reg.init) begin
            if (trig) begin
                state_next.armed = 1'b1;
            end else begin
                state_next.hold_off = 1'b0;
            end
            if (man_reset && act == alarm_pkg::DELAYED_LATCH_ACTION) begin
                state_next.pend = 1'b1;
            end
            case (state_reg.st)
                alarm_pkg::ST_IDLE: begin
                    if (trig && (state_reg.armed || !stby) && !state_reg.hold_off) begin
                        state_next.st  = (lead_dly == 16'h0000) ? alarm_pkg::ST_ACTIVE : alarm_pkg::ST_ON_DLY;
                        state_next.cnt = lead_dly;
                    end
                end
                alarm_pkg::ST_ON_DLY: begin
                    if (!trig) begin
                        state_next.st = alarm_pkg::ST_IDLE;
                    end else if (state_reg.cnt == 16'h0000) begin
                        state_next.st = alarm_pkg::ST_ACTIVE;
                    end
                end
                alarm_pkg::ST_ACTIVE: begin
                    if (man_reset && act != alarm_pkg::DELAYED_LATCH_ACTION) begin
                        state_next.st = alarm_pkg::ST_IDLE;
                        state_next.hold_off = trig;
                    end else if (!trig && act == alarm_pkg::AUTO_ACTION) begin
                        state_next.st  = (trail_dly == 16'h0000) ? alarm_pkg::ST_IDLE : alarm_pkg::ST_OFF_DLY;
                        state_next.cnt = trail_dly;
                    end else if (!trig && act == alarm_pkg::DELAYED_LATCH_ACTION && state_reg.pend) begin
                        state_next.st   = alarm_pkg::ST_IDLE;
                        state_next.pend = 1'b0;
                    end
                end
                alarm_pkg::ST_OFF_DLY: begin
                    if (trig) begin
                        state_next.st = alarm_pkg::ST_ACTIVE;
                    end else if (state_reg.cnt == 16'h0000) begin
                        state_next.st = alarm_pkg::ST_IDLE;
                    end
                end
                default: state_next.st = alarm_pkg::ST_IDLE;
            endcase
            // auto alarms follow new values; latched ones hold
            if (list_change && act == alarm_pkg::AUTO_ACTION && !trig) begin
                state_next.st = alarm_pkg::ST_IDLE;
            end
        end
        if (!cfg[alarm_pkg::CFG_ENA_BIT]) begin
            state_next.st = alarm_pkg::ST_IDLE;
        end
        if (probe_fail) begin
            state_next.out = cfg[alarm_pkg::CFG_BURN_ON_BIT];
        end else begin
            state_next.out = ((state_next.st == alarm_pkg::ST_ACTIVE) || (state_next.st == alarm_pkg::ST_OFF_DLY)) ^ rev;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= '{st: alarm_pkg::ST_IDLE, cnt: 16'h0000, pend: 1'b0,
                           armed: 1'b0, hold_off: 1'b0, init: 1'b1, out: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign alarm_out = state_reg.out;
    assign active    = (state_reg.st == alarm_pkg::ST_ACTIVE) || (state_reg.st == alarm_pkg::ST_OFF_DLY);
endmodule

// ===== rtl/alarm_output_logic.sv
// Overview of operation
// - tripped output held on for programmed off-delay after release
// - zero delay means no extra wait, normal update rate
// - reversed logic moves off-delay to the turn-on edge
// - delay progress is cleared at power-up
// - output driven directly, or inverted under reversed polarity
// - automatic action turns output off when trigger releases
// - automatic action: manual reset forces alarm off until retrigger; here ignored while off-delay runs
// - immediate latch held until manual, serial reset or power cycle
// - delayed latch reset waits pending until trigger-off crossing
// - latched alarms start off at power-up when below setpoint
// - pending delayed reset dropped at power-up unless input still active
// - standby suppresses alarm after power-up until the update after the first trigger
// - indicator off, lit active, lit inactive, or flashing active
// - probe failure forces each output to its burn-out state
// - alternate setpoint list kept; main list preserved while inactive
// - list switched only by key or user input with list select
// - on list change auto alarms re-evaluate, latched alarms stay
// - on-delay before turn-on; reversed logic moves it to turn-off
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/100ps
module alarm_output_logic (
    input  wire logic        mclk,
    input  wire logic        rst,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // measurement side
    input  wire logic        meas_update,
    input  wire logic [3:0]  trig,
    input  wire logic [3:0]  below_sp,
    input  wire logic        probe_fail,
    // manual reset and list select pins
    input  wire logic [3:0]  reset_key,
    input  wire logic        list_select_function,
    output logic [3:0]       alarm_out,
    output logic [3:0]       indicator,
    output logic             alt_list_active
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic                    awpend;
        logic [7:0]              awaddr;
        logic                    wpend;
        logic [31:0]             wdata;
        logic [3:0]              wstrb;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [31:0]             rdata;
        logic [1:0]              rresp;
        logic                    alt;
        logic [3:0]              cmd_rst;
        logic [3:0][7:0]         cfg;
        logic [3:0][15:0]        on_dly;
        logic [3:0][15:0]        off_dly;
        logic [3:0]              key_s1;
        logic [3:0]              key_s2;
        logic                    sel_s1;
        logic                    sel_s2;
        logic                    sel_d;
        logic [3:0]              rst_hold;
        logic                    chg;
        logic [23:0]             div;
        logic [3:0]              flash_cnt;
        logic                    flash;
        logic [3:0]              ind;
        logic [3:0]              out;
    } top_s;

    top_s s_reg;
    top_s s_next;

    logic [3:0] ch_out;
    logic [3:0] ch_active;
    logic       tick;
    logic       wr_fire;

    assign tick    = (s_reg.div == 24'(alarm_pkg::TENTH_CYCLES - 1));
    assign wr_fire = s_reg.awpend && s_reg.wpend && !s_reg.bvalid;

    // decoding used by both read and write paths
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == alarm_pkg::CTRL_OFS) || (a == alarm_pkg::STATUS_OFS) || (a == alarm_pkg::CMD_OFS)
                || (a[7:4] == alarm_pkg::CFG_OFS[7:4] && a[1:0] == 2'b00)
                || (a[7:4] == alarm_pkg::ONDLY_OFS[7:4] && a[1:0] == 2'b00)
                || (a[7:4] == alarm_pkg::OFFDLY_OFS[7:4] && a[1:0] == 2'b00);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = be[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // ****************************************************************
    // channels
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < alarm_pkg::NUM_SP; g++) begin : gen_ch
            setpoint_channel u_ch (
                .mclk        (mclk),
                .rst         (rst),
                .update      (meas_update),
                .tick        (tick),
                .trig        (trig[g]),
                .below_sp    (below_sp[g]),
                .probe_fail  (probe_fail),
                .man_reset   (s_reg.rst_hold[g]),
                .list_change (s_reg.chg),
                .cfg         (s_reg.cfg[g]),
                .on_dly      (s_reg.on_dly[g]),
                .off_dly     (s_reg.off_dly[g]),
                .alarm_out   (ch_out[g]),
                .active      (ch_active[g])
            );
        end
    endgenerate

    always_comb begin
        logic [31:0] m;
        logic [1:0]  idx;
        m      = 32'h0000_0000;
        idx    = 2'b00;
        s_next = s_reg;
        // ------------------------------------------------------------
        // pins: two flops before use
        // ------------------------------------------------------------
        s_next.key_s1 = reset_key;
        s_next.key_s2 = s_reg.key_s1;
        s_next.sel_s1 = list_select_function;
        s_next.sel_s2 = s_reg.sel_s1;
        s_next.sel_d  = s_reg.sel_s2;
        // list toggles only on the assigned key edge
        if (s_reg.sel_s2 && !s_reg.sel_d) begin
            s_next.alt = !s_reg.alt;
            s_next.chg = 1'b1;
        end
        // manual reset requests held until next measurement update
        s_next.rst_hold = s_reg.rst_hold | s_reg.key_s2 | s_reg.cmd_rst;
        if (meas_update) begin
            s_next.rst_hold = s_reg.key_s2 | s_reg.cmd_rst;
            s_next.chg      = s_reg.sel_s2 && !s_reg.sel_d;
        end
        s_next.cmd_rst = 4'h0;
        // ------------------------------------------------------------
        // time base and flash
        // ------------------------------------------------------------
        s_next.div = tick ? 24'h000000 : s_reg.div + 24'h000001;
        if (tick) begin
            if (s_reg.flash_cnt == 4'(alarm_pkg::FLASH_TENTHS - 1)) begin
                s_next.flash_cnt = 4'h0;
                s_next.flash     = !s_reg.flash;
            end else begin
                s_next.flash_cnt = s_reg.flash_cnt + 4'h1;
            end
        end
        for (int i = 0; i < alarm_pkg::NUM_SP; i++) begin
            case (alarm_pkg::indicator_mode_e'(s_reg.cfg[i][alarm_pkg::CFG_IND_LSB +: 2]))
                alarm_pkg::IND_OFF:                 s_next.ind[i] = 1'b0;
                alarm_pkg::IND_NORMAL:              s_next.ind[i] = ch_active[i];
                alarm_pkg::IND_REVERSED:            s_next.ind[i] = !ch_active[i];
                alarm_pkg::FLASHING_INDICATOR_MODE: s_next.ind[i] = ch_active[i] & s_reg.flash;
                default:                            s_next.ind[i] = 1'b0;
            endcase
        end
        s_next.out = ch_out;
        // ------------------------------------------------------------
        // axi4-lite write
        // ------------------------------------------------------------
        if (s_axi_awvalid && !s_reg.awpend) begin
            s_next.awpend = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.wpend) begin
            s_next.wpend = 1'b1;
            s_next.wdata = s_axi_wdata;
            s_next.wstrb = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (wr_fire) begin
            s_next.awpend = 1'b0;
            s_next.wpend  = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp  = addr_ok(s_reg.awaddr) ? 2'b00 : 2'b10;
            idx           = s_reg.awaddr[3:2];
            // list is read-only to software: only the select pin may switch it
            if (s_reg.awaddr == alarm_pkg::CMD_OFS && s_reg.wstrb[0]) begin
                s_next.cmd_rst = s_reg.wdata[alarm_pkg::CMD_RST_LSB +: 4];
            end else if (s_reg.awaddr[7:4] == alarm_pkg::CFG_OFS[7:4] && addr_ok(s_reg.awaddr)) begin
                m = merge({24'h000000, s_reg.cfg[idx]}, s_reg.wdata, s_reg.wstrb);
                s_next.cfg[idx] = m[7:0];
            end else if (s_reg.awaddr[7:4] == alarm_pkg::ONDLY_OFS[7:4] && addr_ok(s_reg.awaddr)) begin
                m = merge({16'h0000, s_reg.on_dly[idx]}, s_reg.wdata, s_reg.wstrb);
                s_next.on_dly[idx] = (m[15:0] > alarm_pkg::DLY_MAX_TENTHS) ? alarm_pkg::DLY_MAX_TENTHS : m[15:0];
            end else if (s_reg.awaddr[7:4] == alarm_pkg::OFFDLY_OFS[7:4] && addr_ok(s_reg.awaddr)) begin
                m = merge({16'h0000, s_reg.off_dly[idx]}, s_reg.wdata, s_reg.wstrb);
                s_next.off_dly[idx] = (m[15:0] > alarm_pkg::DLY_MAX_TENTHS) ? alarm_pkg::DLY_MAX_TENTHS : m[15:0];
            end
        end
        // ------------------------------------------------------------
        // axi4-lite read
        // ------------------------------------------------------------
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_reg.rvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = addr_ok(s_axi_araddr) ? 2'b00 : 2'b10;
            idx           = s_axi_araddr[3:2];
            s_next.rdata  = 32'h0000_0000;
            if (s_axi_araddr == alarm_pkg::CTRL_OFS) begin
                s_next.rdata = {31'h00000000, s_reg.alt};
            end else if (s_axi_araddr == alarm_pkg::STATUS_OFS) begin
                s_next.rdata = {20'h00000, s_reg.ind, ch_active, s_reg.out};
            end else if (s_axi_araddr[7:4] == alarm_pkg::CFG_OFS[7:4] && addr_ok(s_axi_araddr)) begin
                s_next.rdata = {24'h000000, s_reg.cfg[idx]};
            end else if (s_axi_araddr[7:4] == alarm_pkg::ONDLY_OFS[7:4] && addr_ok(s_axi_araddr)) begin
                s_next.rdata = {16'h0000, s_reg.on_dly[idx]};
            end else if (s_axi_araddr[7:4] == alarm_pkg::OFFDLY_OFS[7:4] && addr_ok(s_axi_araddr)) begin
                s_next.rdata = {16'h0000, s_reg.off_dly[idx]};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_reg     <= '0;
            s_reg.cfg <= {4{alarm_pkg::CFG_RESET}};
            s_reg.alt <= alarm_pkg::CTRL_RESET[alarm_pkg::CTRL_ALT_LIST_BIT];
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************************************
    // outputs, all from flops
    // ****************************************************************
    assign s_axi_awready   = !s_reg.awpend;
    assign s_axi_wready    = !s_reg.wpend;
    assign s_axi_bvalid    = s_reg.bvalid;
    assign s_axi_bresp     = s_reg.bresp;
    assign s_axi_arready   = !s_reg.rvalid;
    assign s_axi_rvalid    = s_reg.rvalid;
    assign s_axi_rdata     = s_reg.rdata;
    assign s_axi_rresp     = s_reg.rresp;
    assign alarm_out       = s_reg.out;
    assign indicator       = s_reg.ind;
    assign alt_list_active = s_reg.alt;
endmodule

// ===== testbench/alarm_props.sv
`timescale 1ns/100ps
// ****************
// port checks
// ****************
module alarm_props (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        list_select_function,
    input wire logic [3:0]  alarm_out,
    input wire logic        alt_list_active
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read lost");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    rd_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read stuck");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
    unmapped_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'hf0
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read ok");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    reset_out_a: assert property ($fell(rst) |-> alarm_out == 4'h0 && !alt_list_active)
        else $error("outputs not cleared");
    // synchroniser plus edge detect sets the lag
    list_toggle_a: assert property ($rose(list_select_function) |-> ##[2:6] $changed(alt_list_active))
        else $error("list not toggled");
    cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
    cover property (alarm_out != 4'h0);
    cover property ($rose(alt_list_active));
endmodule
bind alarm_output_logic alarm_props u_alarm_props (.mclk, .rst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
    .list_select_function, .alarm_out, .alt_list_active);

// ===== testbench/panel_keys.sv
`timescale 1ns/100ps
// ****************
// front panel keys and user inputs
// ****************
module panel_keys (
    input  wire logic       mclk,
    input  wire logic [3:0] key_req,
    input  wire logic       list_req,
    output logic [3:0]      reset_key,
    output logic            list_select_function
);
    initial reset_key = 4'h0;
    initial list_select_function = 1'b0;
    // held or momentary press both reach the pins
    always @(posedge mclk) begin
        reset_key <= key_req;
        list_select_function <= list_req;
    end
endmodule

// ===== testbench/tb_alarm_output_logic.sv
`timescale 1ns/100ps
module tb_alarm_output_logic;
    logic        mclk = 1'b0, rst = 1'b1, meas_update = 1'b0, probe_fail = 1'b0, list_req = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        alt_list_active, list_select_function;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf, trig = 4'h0, below_sp = 4'h0, key_req = 4'h0, reset_key, alarm_out, indicator;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    int          failures = 0, comparisons = 0;
    alarm_output_logic u_alarm_output_logic (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .meas_update, .trig, .below_sp, .probe_fail, .reset_key, .list_select_function, .alarm_out, .indicator,
        .alt_list_active);
    panel_keys u_panel_keys (.mclk, .key_req, .list_req, .reset_key, .list_select_function);
    initial forever #20 mclk = ~mclk;
    // ****************
    // shared tasks
    // ****************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rdr(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic upd(input logic [3:0] t);
        trig <= t;
        meas_update <= 1'b1;
        @(posedge mclk);
        meas_update <= 1'b0;
        repeat (5) @(posedge mclk);
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_regs;
        rdr(8'h00);
        chk("ctrl reset", rd, 32'h0);
        rdr(8'h10);
        chk("cfg0 reset", rd, 32'h0);
        rdr(8'hf0);
        chk("unmapped read", 32'(rsp), 32'h2);
        wr(8'hf0, 32'h1);
        chk("unmapped write", 32'(rsp), 32'h2);
        wr(8'h20, 32'hffff);
        rdr(8'h20);
        chk("delay clamp", rd, {16'h0, alarm_pkg::DLY_MAX_TENTHS});
        wr(8'h20, 32'h0);
        $display("regs done");
    endtask
    task automatic t_auto;
        wr(8'h10, 32'h90);
        upd(4'h1);
        chk("auto on", 32'(alarm_out[0]), 32'h1);
        chk("lit active", 32'(indicator[0]), 32'h1);
        key_req <= 4'h1;
        repeat (5) @(posedge mclk);
        upd(4'h1);
        chk("manual off", 32'(alarm_out[0]), 32'h0);
        key_req <= 4'h0;
        upd(4'h1);
        chk("stays off", 32'(alarm_out[0]), 32'h0);
        upd(4'h0);
        upd(4'h1);
        chk("retrigger", 32'(alarm_out[0]), 32'h1);
        upd(4'h0);
        chk("auto release", 32'(alarm_out[0]), 32'h0);
        $display("auto done");
    endtask
    task automatic t_latch;
        wr(8'h14, 32'h82);
        upd(4'h2);
        upd(4'h0);
        chk("latch held", 32'(alarm_out[1]), 32'h1);
        chk("ind mode off", 32'(indicator[1]), 32'h0);
        wr(8'h08, 32'h2);
        upd(4'h0);
        chk("serial clear", 32'(alarm_out[1]), 32'h0);
        wr(8'h14, 32'h84);
        upd(4'h2);
        wr(8'h08, 32'h2);
        upd(4'h2);
        chk("reset pending", 32'(alarm_out[1]), 32'h1);
        upd(4'h0);
        chk("delayed clear", 32'(alarm_out[1]), 32'h0);
        $display("latch done");
    endtask
    task automatic t_rev;
        wr(8'h18, 32'ha1);
        upd(4'h0);
        chk("rev idle", 32'(alarm_out[2]), 32'h1);
        chk("lit inactive", 32'(indicator[2]), 32'h1);
        upd(4'h4);
        chk("rev active", 32'(alarm_out[2]), 32'h0);
        $display("rev done");
    endtask
    task automatic t_burn;
        wr(8'h1c, 32'hc0);
        probe_fail <= 1'b1;
        repeat (5) @(posedge mclk);
        chk("burn on", 32'(alarm_out[3]), 32'h1);
        chk("burn off", 32'(alarm_out[0]), 32'h0);
        probe_fail <= 1'b0;
        $display("burn done");
    endtask
    task automatic t_list;
        list_req <= 1'b1;
        repeat (8) @(posedge mclk);
        chk("alt on", 32'(alt_list_active), 32'h1);
        list_req <= 1'b0;
        repeat (8) @(posedge mclk);
        chk("alt kept", 32'(alt_list_active), 32'h1);
        wr(8'h00, 32'h0);
        chk("no bus switch", 32'(alt_list_active), 32'h1);
        $display("list done");
    endtask
    task automatic summarize;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        upd(4'h0);
        t_regs;
        t_auto;
        t_latch;
        t_rev;
        t_burn;
        t_list;
        summarize;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        summarize;
    end
endmodule
